// *** irq_flags.sv ***
// Interrupt acceptance flags: enable, stack select and priority level logic
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// - Maskable requests refused while enable flag zero
// - Acknowledge clears the enable flag
// - Stack select zero interrupt, one user stack
// - Hardware ack or swi 0-31 clear select
// - Priority level is three bits, 0 to 7
// - Accept only priority strictly above current level; software requests are taken at any level
// - Reserved bit written zero, read undefined
// - Five external, 23 peripheral, four software sources
module irq_flags
    import irq_flags_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EXT_SOURCES-1:0] ext_req,
    input wire logic [PER_SOURCES-1:0] per_req,
    input wire logic ack_ready,
    output logic ack_valid,
    output logic [SRC_IDX_W-1:0] ack_source,
    output logic use_user_stack
);

    // ------------------------------------------------------------
    // Input synchronisers for external pins
    // ------------------------------------------------------------
    logic [EXT_SOURCES-1:0] ext_meta;   // First stage, read only by second
    logic [EXT_SOURCES-1:0] ext_sync;   // Safe to use

    // External lines come from pins, so they pass two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta <= '0;
            ext_sync <= '0;
        end else begin
            ext_meta <= ext_req;
            ext_sync <= ext_meta;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    flags_t flags;                           // Live flags
    flags_t next_flags;
    logic [SW_SOURCES-1:0] swi_pend;         // Pending software requests
    logic [SW_SOURCES-1:0] next_swi_pend;
    logic [SWI_NUM_W-1:0] swi_num [SW_SOURCES];   // Instruction number per slot
    logic [SWI_NUM_W-1:0] next_swi_num [SW_SOURCES];
    logic [LEVEL_W-1:0] prio [NUM_SOURCES];  // Priority per source
    logic [LEVEL_W-1:0] next_prio [NUM_SOURCES];
    ack_info_t last_ack;                     // Last acknowledge, for status read
    ack_info_t next_last_ack;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_ack_valid;
    logic [SRC_IDX_W-1:0] next_ack_source;

    // ------------------------------------------------------------
    // Request collection and arbitration
    // ------------------------------------------------------------
    logic [NUM_SOURCES-1:0] req_all;    // All 32 request lines
    logic take;                         // A request wins this cycle
    logic [SRC_IDX_W-1:0] win_idx;      // Winning source
    logic [LEVEL_W-1:0] win_lvl;        // Its level
    logic win_found;

    assign req_all = {swi_pend, per_req, ext_sync};

    // Highest level wins; lowest index breaks ties. Software
    // requests are not maskable, so they bypass enable and level.
    // Limitation: software slots are served lowest first, so a slot
    // that software keeps re-arming can hold back the higher slots.
    always_comb begin
        win_found = 1'b0;
        win_idx = '0;
        win_lvl = '0;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            if (i >= EXT_SOURCES + PER_SOURCES) begin
                if (req_all[i] && !(win_found && win_idx >= SRC_IDX_W'(EXT_SOURCES + PER_SOURCES))) begin
                    // Software request takes precedence over maskable ones
                    win_found = 1'b1;
                    win_idx = SRC_IDX_W'(i);
                    win_lvl = {LEVEL_W{1'b1}};
                end
            end else if (req_all[i] && flags.enable
                         && prio[i] > flags.processor_priority_level
                         && (!win_found || prio[i] > win_lvl)) begin
                win_found = 1'b1;
                win_idx = SRC_IDX_W'(i);
                win_lvl = prio[i];
            end
        end
        // Only while the core can take one and nothing is outstanding
        take = win_found && ack_ready && !ack_valid;
    end

    // ------------------------------------------------------------
    // Next state: flags, software slots, priorities, APB answer
    // ------------------------------------------------------------
    always_comb begin
        logic wr;
        logic rd;
        int swi_slot;
        wr = psel && penable && pwrite && !pready;
        rd = psel && penable && !pwrite && !pready;
        swi_slot = 0;
        next_flags = flags;
        next_swi_pend = swi_pend;
        next_swi_num = swi_num;
        next_prio = prio;
        next_last_ack = last_ack;
        next_last_ack.valid = 1'b0;
        next_prdata = '0;
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_ack_valid = 1'b0;
        next_ack_source = ack_source;

        // Software writes come first so hardware events override them
        if (wr) begin
            unique case (paddr)
                FLAG_OFFSET: begin
                    // Reserved bit ignored on write
                    next_flags.enable = pwdata[ENABLE_BIT];
                    next_flags.stack_sel = pwdata[STACK_SEL_BIT];
                    next_flags.processor_priority_level =
                        pwdata[LEVEL_LSB +: LEVEL_W];
                end
                SWI_OFFSET: begin
                    // Slot in bits 9:8, instruction number in bits 5:0
                    swi_slot = int'(pwdata[9:8]);
                    next_swi_pend[swi_slot] = 1'b1;
                    next_swi_num[swi_slot] = pwdata[SWI_NUM_W-1:0];
                end
                PRIO_OFFSET: begin
                    if (int'(pwdata[12:8]) < EXT_SOURCES + PER_SOURCES)
                        next_prio[int'(pwdata[12:8])] = pwdata[LEVEL_W-1:0];
                end
                STAT_OFFSET: begin
                    next_pslverr = 1'b1;   // Status is read only
                end
                default: begin
                    next_pslverr = 1'b1;   // Unmapped address
                end
            endcase
        end else if (rd) begin
            unique case (paddr)
                FLAG_OFFSET: begin
                    next_prdata[ENABLE_BIT] = flags.enable;
                    next_prdata[STACK_SEL_BIT] = flags.stack_sel;
                    next_prdata[RESERVED_BIT] = 1'b0;
                    next_prdata[LEVEL_LSB +: LEVEL_W] = flags.processor_priority_level;
                end
                STAT_OFFSET: begin
                    next_prdata[SRC_IDX_W-1:0] = last_ack.source;
                    next_prdata[8] = last_ack.hardware;
                    next_prdata[19:16] = swi_pend;
                end
                SWI_OFFSET: begin
                    next_prdata[3:0] = swi_pend;
                end
                PRIO_OFFSET: begin
                    next_prdata = '0;   // Write only window
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end

        // Acknowledge side effects win over a same cycle write, except a re-arm of the taken slot
        if (take) begin
            next_ack_valid = 1'b1;
            next_ack_source = win_idx;
            next_flags.enable = 1'b0;
            next_last_ack.valid = 1'b1;
            next_last_ack.source = win_idx;
            if (win_idx < SRC_IDX_W'(EXT_SOURCES + PER_SOURCES)) begin
                next_last_ack.hardware = 1'b1;
                next_flags.stack_sel = 1'b0;
            end else begin
                next_last_ack.hardware = 1'b0;
                swi_slot = int'(win_idx) - (EXT_SOURCES + PER_SOURCES);
                // A write that re-arms this very slot in the same cycle
                // must not be lost under the acknowledge: the set wins
                if (!(wr && paddr == SWI_OFFSET && int'(pwdata[9:8]) == swi_slot)) begin
                    next_swi_pend[swi_slot] = 1'b0;
                end
                // Numbers above the limit leave the select alone
                if (swi_num[swi_slot] <= SWI_STACK_LIMIT)
                    next_flags.stack_sel = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags.enable <= ENABLE_RESET;
            flags.stack_sel <= STACK_SEL_RESET;
            flags.processor_priority_level <= LEVEL_RESET;
            swi_pend <= '0;
            for (int i = 0; i < SW_SOURCES; i++) swi_num[i] <= '0;
            for (int i = 0; i < NUM_SOURCES; i++) prio[i] <= '0;
            last_ack <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ack_valid <= 1'b0;
            ack_source <= '0;
            use_user_stack <= 1'b0;
        end else begin
            flags <= next_flags;
            swi_pend <= next_swi_pend;
            swi_num <= next_swi_num;
            prio <= next_prio;
            last_ack <= next_last_ack;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ack_valid <= next_ack_valid;
            ack_source <= next_ack_source;
            use_user_stack <= next_flags.stack_sel;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_ack_clears_enable: assert property (@(posedge pclk) disable iff (!presetn)
        ack_valid |-> !flags.enable)
        else $error("enable flag still set after acknowledge");
    chk_masked_refused: assert property (@(posedge pclk) disable iff (!presetn)
        (take && win_idx < SRC_IDX_W'(EXT_SOURCES + PER_SOURCES)) |-> flags.enable)
        else $error("maskable request taken while disabled");
    chk_level_strict: assert property (@(posedge pclk) disable iff (!presetn)
        (take && win_idx < SRC_IDX_W'(EXT_SOURCES + PER_SOURCES))
        |-> prio[win_idx] > flags.processor_priority_level)
        else $error("request taken at or below current level");
    chk_hw_stack_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (take && win_idx < SRC_IDX_W'(EXT_SOURCES + PER_SOURCES)) |=> !flags.stack_sel)
        else $error("stack select not cleared on hardware acknowledge");
    chk_stack_output: assert property (@(posedge pclk) disable iff (!presetn)
        use_user_stack == flags.stack_sel)
        else $error("stack output disagrees with flag");
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pready) && $past(paddr) == FLAG_OFFSET |-> prdata[RESERVED_BIT] == 1'b0)
        else $error("reserved bit read nonzero");
    chk_ack_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        ack_valid |=> !ack_valid)
        else $error("acknowledge longer than one cycle");
    chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer late");
    // Each access is answered by exactly one ready pulse
    chk_apb_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("apb ready held longer than one cycle");
    // Low-numbered software interrupts must land on the interrupt stack.
    // Slots sit at the top four indices, so the low two bits pick the slot.
    chk_swi_low_stack: assert property (@(posedge pclk) disable iff (!presetn)
        (take && win_idx >= SRC_IDX_W'(EXT_SOURCES + PER_SOURCES)
         && swi_num[win_idx[1:0]] <= SWI_STACK_LIMIT) |=> !flags.stack_sel)
        else $error("stack select not cleared on low software interrupt");
    // High-numbered software interrupts leave the selection alone; a flag
    // write in the same cycle is excluded, since software may change it then
    chk_swi_high_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (take && win_idx >= SRC_IDX_W'(EXT_SOURCES + PER_SOURCES)
         && swi_num[win_idx[1:0]] > SWI_STACK_LIMIT
         && !(psel && penable && pwrite && !pready && paddr == FLAG_OFFSET))
        |=> flags.stack_sel == $past(flags.stack_sel))
        else $error("stack select changed by high software interrupt");

    // ------------------------------------------------------------
    // Coverage of the main acknowledge scenarios
    // ------------------------------------------------------------
    cov_hw_ack: cover property (@(posedge pclk) disable iff (!presetn)
        take && win_idx < SRC_IDX_W'(EXT_SOURCES));
    cov_per_ack: cover property (@(posedge pclk) disable iff (!presetn)
        take && win_idx >= SRC_IDX_W'(EXT_SOURCES) && win_idx < SRC_IDX_W'(28));
    cov_swi_ack: cover property (@(posedge pclk) disable iff (!presetn)
        take && win_idx >= SRC_IDX_W'(28));
    cov_masked: cover property (@(posedge pclk) disable iff (!presetn)
        |per_req && !flags.enable);
    // High software number taken while the user stack is selected
    cov_swi_keep_user: cover property (@(posedge pclk) disable iff (!presetn)
        take && win_idx >= SRC_IDX_W'(28) && swi_num[win_idx[1:0]] > SWI_STACK_LIMIT
        && flags.stack_sel);

endmodule : irq_flags

// *** irq_flags_pkg.sv ***
// Package for the processor interrupt acceptance flag block
package irq_flags_pkg;

    // ------------------------------------------------------------
    // Source counts and widths
    // ------------------------------------------------------------
    localparam int EXT_SOURCES = 5;    // External request lines
    localparam int PER_SOURCES = 23;   // Internal peripheral request lines
    localparam int SW_SOURCES = 4;     // Software request lines
    localparam int NUM_SOURCES = EXT_SOURCES + PER_SOURCES + SW_SOURCES;
    localparam int LEVEL_W = 3;        // Priority level field width
    localparam int SRC_IDX_W = 5;      // Index width for 32 sources
    localparam int SWI_NUM_W = 6;      // Software interrupt number width
    localparam logic [SWI_NUM_W-1:0] SWI_STACK_LIMIT = 6'h1F;  // Highest number that selects the interrupt stack

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] FLAG_OFFSET = 8'h00;   // Flag register
    localparam logic [7:0] STAT_OFFSET = 8'h04;   // Acknowledge status register
    localparam logic [7:0] SWI_OFFSET = 8'h08;    // Software interrupt trigger
    localparam logic [7:0] PRIO_OFFSET = 8'h0C;   // Per source priority (index in bits 12:8)

    // ------------------------------------------------------------
    // Flag register field positions and reset values
    // ------------------------------------------------------------
    localparam int ENABLE_BIT = 0;       // Maskable interrupt enable
    localparam int STACK_SEL_BIT = 1;    // Stack select: 0 interrupt stack, 1 user stack
    localparam int RESERVED_BIT = 2;     // Reserved, reads as zero here
    localparam int LEVEL_LSB = 4;        // Processor priority level field
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic STACK_SEL_RESET = 1'b0;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h0;

    // ------------------------------------------------------------
    // Carried groups
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;                  // Acknowledge happened this cycle
        logic hardware;               // Taken source was a hardware request
        logic [SRC_IDX_W-1:0] source; // Index of taken source
    } ack_info_t;

    typedef struct packed {
        logic enable;                       // Maskable enable flag
        logic stack_sel;                    // Stack select flag
        logic [LEVEL_W-1:0] processor_priority_level; // Current level
    } flags_t;

endpackage : irq_flags_pkg

// *** irq_src_model.sv ***
// Behavioural request sources that sit in front of the acceptance flag block
`timescale 1ns/1ps

module irq_src_model
    import irq_flags_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [EXT_SOURCES+PER_SOURCES-1:0] raise,
    input wire logic ack_valid,
    input wire logic [SRC_IDX_W-1:0] ack_source,
    output logic [EXT_SOURCES-1:0] ext_req,
    output logic [PER_SOURCES-1:0] per_req
);
    // ------------------------------------------------------------
    // Request levels
    // ------------------------------------------------------------
    logic [EXT_SOURCES+PER_SOURCES-1:0] pending; // One level per hardware source
    logic [EXT_SOURCES+PER_SOURCES-1:0] next_pending; // Level after this edge

    // A level is not latched by the core, so it holds until its own acknowledge
    always_comb begin
        next_pending = pending | raise;
        if (ack_valid) begin
            next_pending = next_pending & ~(28'h000_0001 << ack_source);
        end
    end

    // Registered only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // Five external lines first, then the peripheral lines
    assign ext_req = pending[EXT_SOURCES-1:0];
    assign per_req = pending[EXT_SOURCES+PER_SOURCES-1:EXT_SOURCES];
endmodule : irq_src_model

// *** cpu_interrupt_acceptance_flags_bench.sv ***
// Self-checking bench for the interrupt acceptance flag block
`timescale 1ns/1ps

module cpu_interrupt_acceptance_flags_bench
    import irq_flags_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [EXT_SOURCES-1:0] ext_req;
    logic [PER_SOURCES-1:0] per_req;
    logic ack_ready = 1'b1;
    logic ack_valid;
    logic [SRC_IDX_W-1:0] ack_source;
    logic use_user_stack;
    logic [EXT_SOURCES+PER_SOURCES-1:0] raise = '0; // Pulse that starts a source
    logic [31:0] rd_data; // Data of the last transfer
    logic rd_err; // Error flag of the last transfer
    int error_cnt = 0;
    int cmp_count = 0;
    logic [4:0] hw_list [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1B};

    always #5 pclk = ~pclk;

    irq_flags u_irq_flags (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_req(ext_req), .per_req(per_req), .ack_ready(ack_ready),
        .ack_valid(ack_valid), .ack_source(ack_source), .use_user_stack(use_user_stack));

    irq_src_model u_irq_src_model (.pclk(pclk), .presetn(presetn), .raise(raise),
        .ack_valid(ack_valid), .ack_source(ack_source), .ext_req(ext_req), .per_req(per_req));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Verdict and end of run
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Compare one value
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer however long it takes; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Flag word; the reserved bit is always written as zero
    function automatic logic [31:0] flags(input logic en, input logic ss, input logic [2:0] lv);
        flags = 32'h0000_0000;
        flags[ENABLE_BIT] = en;
        flags[STACK_SEL_BIT] = ss;
        flags[LEVEL_LSB +: LEVEL_W] = lv;
    endfunction : flags

    // Read the flags and ignore the reserved bit, whose read value is undefined
    task automatic check_flags(input logic [31:0] exp);
        apb(1'b0, FLAG_OFFSET, 32'h0000_0000);
        check("flags", exp, rd_data & ~(32'h0000_0001 << RESERVED_BIT));
    endtask : check_flags

    // Start one hardware source
    task automatic fire(input int src);
        @(posedge pclk);
        raise <= 28'h000_0001 << src;
        @(posedge pclk);
        raise <= '0;
    endtask : fire

    // Wait a bounded time for an acknowledge and compare the source
    task automatic wait_ack(input logic [4:0] src);
        int n;
        n = 0;
        forever begin
            @(negedge pclk);
            n++;
            if (ack_valid === 1'b1 || n > 30) break;
        end
        check("ack_valid", 32'h0000_0001, {31'h0, ack_valid});
        check("ack_source", {27'h0, src}, {27'h0, ack_source});
    endtask : wait_ack

    // No acknowledge may appear for n cycles
    task automatic no_ack(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge pclk);
            if (ack_valid !== 1'b0) seen = 1'b1;
        end
        check("no_ack", 32'h0000_0000, {31'h0, seen});
    endtask : no_ack

    // ------------------------------------------------------------
    // Watchdog: the whole run needs well under 3000 cycles
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check_flags(32'h0000_0000);
        check("stack", 32'h0000_0000, {31'h0, use_user_stack});
        // Level field takes every value 0 to 7
        for (int lv = 0; lv < 8; lv++) begin
            apb(1'b1, FLAG_OFFSET, flags(1'b0, 1'b0, lv[2:0]));
            check_flags(flags(1'b0, 1'b0, lv[2:0]));
        end
        // Masked while enable is zero, taken once it is set
        apb(1'b1, FLAG_OFFSET, flags(1'b0, 1'b1, 3'h0));
        check("stack", 32'h0000_0001, {31'h0, use_user_stack});
        apb(1'b1, PRIO_OFFSET, 32'h0000_0501);
        fire(5);
        no_ack(8);
        apb(1'b1, FLAG_OFFSET, flags(1'b1, 1'b1, 3'h0));
        wait_ack(5'h05);
        check("stack", 32'h0000_0000, {31'h0, use_user_stack});
        check_flags(flags(1'b0, 1'b0, 3'h0));
        apb(1'b0, STAT_OFFSET, 32'h0000_0000);
        check("stat", 32'h0000_0105, rd_data & 32'h0000_011F);
        // Equal priority refused, one above taken; core not ready holds it back
        apb(1'b1, FLAG_OFFSET, flags(1'b1, 1'b1, 3'h3));
        apb(1'b1, PRIO_OFFSET, 32'h0000_0603);
        fire(6);
        no_ack(8);
        @(posedge pclk);
        ack_ready <= 1'b0;
        apb(1'b1, PRIO_OFFSET, 32'h0000_0604);
        no_ack(4);
        @(posedge pclk);
        ack_ready <= 1'b1;
        wait_ack(5'h06);
        check_flags(flags(1'b0, 1'b0, 3'h3));
        // All five external lines and the last peripheral line
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, PRIO_OFFSET, {19'h0, hw_list[i], 8'h01});
            apb(1'b1, FLAG_OFFSET, flags(1'b1, 1'b1, 3'h0));
            fire(hw_list[i]);
            wait_ack(hw_list[i]);
            check("stack", 32'h0000_0000, {31'h0, use_user_stack});
        end
        // Four software slots at the edges of the stack-select number range
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, FLAG_OFFSET, flags(1'b0, 1'b1, 3'h7));
            apb(1'b1, SWI_OFFSET, {22'h0, s[1:0], 2'h0, (s < 2) ? 6'h1F * s[0] : 6'h20 + 6'h1F * s[0]});
            wait_ack(5'h1C + s[4:0]);
            check("stack", {31'h0, s >= 2}, {31'h0, use_user_stack});
        end
        // Refused accesses
        apb(1'b0, 8'h10, 32'h0000_0000);
        check("unmapped", 32'h0000_0001, {31'h0, rd_err});
        apb(1'b1, STAT_OFFSET, 32'h0000_0000);
        check("stat_write", 32'h0000_0001, {31'h0, rd_err});
        summarize();
    end
endmodule : cpu_interrupt_acceptance_flags_bench
